// ---- hw/lbcs_bank_tracker.sv ----
// per-bank state tracking and write handling for the low-power dram command path
`timescale 1ns/1ps
module lbcs_bank_tracker
    import lbcs_pkg::*;
#(
    parameter int unsigned NUM_BANKS = BANKS
)(
    input  wire logic                       clock,
    input  wire logic                       nrst,
    input  wire lbcs_pkg::lbcs_cmd_pins_t   cmd_pins,
    input  wire logic                       cke,
    input  wire logic [lbcs_pkg::BYTES*8-1:0] write_data,
    input  wire logic [lbcs_pkg::BYTES-1:0] write_byte_mask,
    output lbcs_pkg::lbcs_write_t           array_write,
    output logic [3*lbcs_pkg::BANKS-1:0]    bank_state_out,
    output logic [lbcs_pkg::ROW_W-1:0]      refresh_row,
    output logic                            refresh_busy,
    output logic                            self_refresh,
    output logic                            deep_power_down
);
    import lbcs_pkg::*;

    // the trackers and the state bus are sized for four banks only
    if (NUM_BANKS != BANKS) begin : g_bank_check
        $error("lbcs_bank_tracker: only four banks supported");
    end

    lbcs_cmd_pins_t   pins_s1_reg, pins_s2_reg;
    logic             cke_s1_reg, cke_s2_reg, cke_prev_reg;
    logic [BYTES*8-1:0] data_s1_reg, data_s2_reg;
    logic [BYTES-1:0] mask_s1_reg, mask_s2_reg;
    lbcs_cmd_t        cmd;
    logic [BANK_W-1:0] cmd_bank;
    logic             ap_sel;
    logic [BANK_W-1:0] last_read_bank_reg;
    logic             last_read_valid_reg;
    logic [CNT_W-1:0] refresh_cnt_reg;

    // pins are from outside the clock domain: two stages before use
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            pins_s1_reg  <= '{cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, default: '0};
            pins_s2_reg  <= '{cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, default: '0};
            cke_s1_reg   <= 1'b0;
            cke_s2_reg   <= 1'b0;
            cke_prev_reg <= 1'b0;
            data_s1_reg  <= '0;
            data_s2_reg  <= '0;
            mask_s1_reg  <= '1;
            mask_s2_reg  <= '1;
        end else begin
            pins_s1_reg  <= cmd_pins;
            pins_s2_reg  <= pins_s1_reg;
            cke_s1_reg   <= cke;
            cke_s2_reg   <= cke_s1_reg;
            cke_prev_reg <= cke_s2_reg;
            data_s1_reg  <= write_data;
            data_s2_reg  <= data_s1_reg;
            mask_s1_reg  <= write_byte_mask;
            mask_s2_reg  <= mask_s1_reg;
        end
    end

    lbcs_cmd_decode u_decode (
        .pins     (pins_s2_reg),
        .cke_prev (cke_prev_reg),
        .cke_now  (cke_s2_reg),
        .cmd      (cmd)
    );

    assign cmd_bank = {pins_s2_reg.bank_select_high, pins_s2_reg.bank_select_low};
    assign ap_sel   = pins_s2_reg.addr[AP_BIT];

    // low-power modes: inputs other than clock enable are ignored while set
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            self_refresh    <= 1'b0;
            deep_power_down <= 1'b0;
        end else begin
            if (cmd == LBCS_CMD_SELF_REFRESH && !self_refresh && !deep_power_down) begin
                self_refresh <= 1'b1;
            end else if (self_refresh && cke_s2_reg) begin
                self_refresh <= 1'b0;
            end
            if (cmd == LBCS_CMD_DEEP_PD && !self_refresh && !deep_power_down) begin
                deep_power_down <= 1'b1;
            end else if (deep_power_down && cke_s2_reg) begin
                deep_power_down <= 1'b0;
            end
        end
    end

    logic busy_mode;
    assign busy_mode = self_refresh || deep_power_down || refresh_busy;

    // refresh counter and refresh period
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            refresh_row     <= '0;
            refresh_busy    <= 1'b0;
            refresh_cnt_reg <= '0;
        end else if (refresh_busy) begin
            if (refresh_cnt_reg == CNT_W'(1)) begin
                refresh_busy <= 1'b0;
            end
            refresh_cnt_reg <= refresh_cnt_reg - CNT_W'(1);
        end else if ((cmd == LBCS_CMD_REFRESH && !self_refresh && !deep_power_down)
                     || (cmd == LBCS_CMD_SELF_REFRESH && !busy_mode)) begin
            // address pins are ignored, the internal counter picks the row
            refresh_row     <= refresh_row + ROW_W'(1);
            refresh_busy    <= (cmd == LBCS_CMD_REFRESH);
            refresh_cnt_reg <= CNT_W'(REFRESH_CYCLE_CYC);
        end
    end

    // most recent read without auto precharge, for burst terminate
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            last_read_bank_reg  <= '0;
            last_read_valid_reg <= 1'b0;
        end else if (!busy_mode) begin
            if (cmd == LBCS_CMD_READ) begin
                last_read_bank_reg  <= cmd_bank;
                last_read_valid_reg <= !ap_sel;
            end else if (cmd == LBCS_CMD_TERM) begin
                last_read_valid_reg <= 1'b0;
            end
        end
    end

    // one tracker per bank
    generate
        for (genvar b = 0; b < BANKS; b++) begin : g_bank
            lbcs_bank_state_t state_reg;
            logic [CNT_W-1:0] cnt_reg;
            logic             hit;
            assign hit = (cmd_bank == BANK_W'(b)) && !busy_mode;

            always_ff @(posedge clock or negedge nrst) begin
                if (!nrst) begin
                    state_reg <= LBCS_BS_IDLE;
                    cnt_reg   <= '0;
                end else if (cmd == LBCS_CMD_PRE && !busy_mode && (ap_sel || hit)) begin
                    state_reg <= LBCS_BS_PRECHARGING;
                    cnt_reg   <= CNT_W'(PRECHARGE_PERIOD_CYC);
                end else begin
                    unique case (state_reg)
                        LBCS_BS_IDLE: begin
                            if (hit && cmd == LBCS_CMD_ACTIVE) begin
                                state_reg <= LBCS_BS_ACTIVATING;
                                cnt_reg   <= CNT_W'(ACT_TO_ACCESS_CYC);
                            end
                        end
                        LBCS_BS_ACTIVATING, LBCS_BS_PRECHARGING: begin
                            cnt_reg <= cnt_reg - CNT_W'(1);
                            if (cnt_reg == CNT_W'(1)) begin
                                state_reg <= (state_reg == LBCS_BS_ACTIVATING) ?
                                             LBCS_BS_ACTIVE : LBCS_BS_IDLE;
                            end
                        end
                        LBCS_BS_ACTIVE, LBCS_BS_READ, LBCS_BS_WRITE: begin
                            if (hit && cmd == LBCS_CMD_READ) begin
                                state_reg <= ap_sel ? LBCS_BS_WRITE_AP : LBCS_BS_READ;
                                cnt_reg   <= CNT_W'(BURST_LEN_CYC);
                            end else if (hit && cmd == LBCS_CMD_WRITE) begin
                                state_reg <= ap_sel ? LBCS_BS_WRITE_AP : LBCS_BS_WRITE;
                                cnt_reg   <= ap_sel ? CNT_W'(BURST_LEN_CYC + WRITE_RECOVERY_CYC)
                                                    : CNT_W'(BURST_LEN_CYC);
                            end else if (cmd == LBCS_CMD_TERM && !busy_mode
                                         && state_reg == LBCS_BS_READ && last_read_valid_reg
                                         && last_read_bank_reg == BANK_W'(b)) begin
                                state_reg <= LBCS_BS_ACTIVE;
                            end else if (state_reg != LBCS_BS_ACTIVE) begin
                                // burst ends by itself, row stays open
                                cnt_reg <= cnt_reg - CNT_W'(1);
                                if (cnt_reg == CNT_W'(1)) begin
                                    state_reg <= LBCS_BS_ACTIVE;
                                end
                            end
                        end
                        LBCS_BS_WRITE_AP: begin
                            // access with auto precharge: precharge after burst, and after write recovery as well for writes
                            cnt_reg <= cnt_reg - CNT_W'(1);
                            if (cnt_reg == CNT_W'(1)) begin
                                state_reg <= LBCS_BS_PRECHARGING;
                                cnt_reg   <= CNT_W'(PRECHARGE_PERIOD_CYC);
                            end
                        end
                    endcase
                end
            end

            always_ff @(posedge clock or negedge nrst) begin
                if (!nrst) begin
                    bank_state_out[3*b +: 3] <= 3'h0;
                end else begin
                    bank_state_out[3*b +: 3] <= state_reg;
                end
            end
        end
    endgenerate

    // write to the array with byte masking; mask bit high keeps the old byte
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            array_write <= '0;
        end else begin
            array_write.valid           <= (cmd == LBCS_CMD_WRITE) && !busy_mode;
            array_write.bank            <= cmd_bank;
            array_write.column          <= pins_s2_reg.addr[COL_W-1:0];
            array_write.data            <= data_s2_reg;
            array_write.write_byte_mask <= mask_s2_reg;
        end
    end
endmodule

// ---- hw/lbcs_cmd_decode.sv ----
// command decoder from strobe pins and clock enable history
`timescale 1ns/1ps
module lbcs_cmd_decode
    import lbcs_pkg::*;
(
    input  wire lbcs_pkg::lbcs_cmd_pins_t pins,
    input  wire logic                     cke_prev,
    input  wire logic                     cke_now,
    output lbcs_pkg::lbcs_cmd_t           cmd
);
    always_comb begin
        cmd = LBCS_CMD_NOP;
        if (!pins.cs_n) begin
            unique case ({pins.ras_n, pins.cas_n, pins.we_n})
                3'h3: cmd = LBCS_CMD_ACTIVE;
                3'h5: cmd = LBCS_CMD_READ;
                3'h4: cmd = LBCS_CMD_WRITE;
                3'h6: cmd = cke_now ? LBCS_CMD_TERM : LBCS_CMD_DEEP_PD;
                3'h2: cmd = LBCS_CMD_PRE;
                3'h1: cmd = cke_now ? LBCS_CMD_REFRESH : LBCS_CMD_SELF_REFRESH;
                3'h0: cmd = LBCS_CMD_LMR;
                default: cmd = LBCS_CMD_NOP;
            endcase
            // bank commands only count with clock enable high on both edges
            if (!(cke_prev && cke_now) && cmd != LBCS_CMD_SELF_REFRESH
                && cmd != LBCS_CMD_DEEP_PD) begin
                cmd = LBCS_CMD_NOP;
            end
            if (cke_prev == 1'b0 && cke_now == 1'b0) begin
                cmd = LBCS_CMD_NOP;
            end
        end
    end
endmodule

// ---- hw/lbcs_pkg.sv ----
// package: command codes, bank states, timing constants for the bank command tracker
package lbcs_pkg;
    localparam int unsigned CLK_MHZ       = 200;
    localparam int unsigned BANKS         = 4;
    localparam int unsigned BANK_W        = 2;
    localparam int unsigned ADDR_W        = 14;
    localparam int unsigned COL_W         = 10;
    localparam int unsigned AP_BIT        = 10;
    localparam int unsigned BYTES         = 2;
    localparam int unsigned ROW_W         = 14;
    // minimum times in ns, rounded up to cycles
    localparam int unsigned PRECHARGE_PERIOD_NS   = 18;
    localparam int unsigned ACT_TO_ACCESS_NS      = 18;
    localparam int unsigned REFRESH_CYCLE_NS      = 72;
    localparam int unsigned WRITE_RECOVERY_NS     = 15;
    localparam int unsigned PRECHARGE_PERIOD_CYC  = (PRECHARGE_PERIOD_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned ACT_TO_ACCESS_CYC     = (ACT_TO_ACCESS_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned REFRESH_CYCLE_CYC     = (REFRESH_CYCLE_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned WRITE_RECOVERY_CYC    = (WRITE_RECOVERY_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned BURST_LEN_CYC = 4;
    localparam int unsigned CNT_W         = 6;

    typedef enum logic [3:0] {
        LBCS_CMD_NOP, LBCS_CMD_ACTIVE, LBCS_CMD_READ, LBCS_CMD_WRITE,
        LBCS_CMD_TERM, LBCS_CMD_PRE, LBCS_CMD_REFRESH, LBCS_CMD_LMR,
        LBCS_CMD_SELF_REFRESH, LBCS_CMD_DEEP_PD
    } lbcs_cmd_t;

    typedef enum logic [2:0] {
        LBCS_BS_IDLE, LBCS_BS_ACTIVATING, LBCS_BS_ACTIVE, LBCS_BS_READ,
        LBCS_BS_WRITE, LBCS_BS_WRITE_AP, LBCS_BS_PRECHARGING
    } lbcs_bank_state_t;

    typedef struct packed {
        logic              cs_n;
        logic              ras_n;
        logic              cas_n;
        logic              we_n;
        logic              bank_select_high;
        logic              bank_select_low;
        logic [ADDR_W-1:0] addr;
    } lbcs_cmd_pins_t;

    typedef struct packed {
        logic              valid;
        logic [BANK_W-1:0] bank;
        logic [COL_W-1:0]  column;
        logic [BYTES*8-1:0] data;
        logic [BYTES-1:0]  write_byte_mask;
    } lbcs_write_t;
endpackage

// ---- tb/lbcs_assertions.sv ----
// checker: port properties of the bank command tracker
`timescale 1ns/1ps
module lbcs_chk
    import lbcs_pkg::*;
#(
    parameter int unsigned NUM_BANKS = BANKS
)(
    input wire lbcs_pkg::lbcs_cmd_pins_t cmd_pins,
    input wire logic                     clock,
    input wire logic                     nrst,
    input wire logic                     cke,
    input wire logic [BYTES*8-1:0]       write_data,
    input wire logic [BYTES-1:0]         write_byte_mask,
    input wire lbcs_pkg::lbcs_write_t    array_write,
    input wire logic [3*BANKS-1:0]       bank_state_out,
    input wire logic [ROW_W-1:0]         refresh_row,
    input wire logic                     refresh_busy,
    input wire logic                     self_refresh,
    input wire logic                     deep_power_down
);
    wire logic [3:0]  code = {cmd_pins.cs_n, cmd_pins.ras_n, cmd_pins.cas_n, cmd_pins.we_n};
    wire logic        calm = !self_refresh && !deep_power_down && !refresh_busy;
    wire logic [29:0] cw   = {cmd_pins.bank_select_high, cmd_pins.bank_select_low,
                              cmd_pins.addr[COL_W-1:0], write_byte_mask, write_data};
    wire logic [29:0] seen = {array_write.bank, array_write.column,
                              array_write.write_byte_mask, array_write.data};
    logic [5:0]       busy_cnt_reg;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!nrst);
    // counted here: a repetition cannot span the whole refresh time
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst)
            busy_cnt_reg <= 6'h00;
        else if (refresh_busy)
            busy_cnt_reg <= busy_cnt_reg + 6'h01;
        else
            busy_cnt_reg <= 6'h00;
    end
    property p_wr_go;
        code == 4'h4 && cke && $past(cke) && calm |-> ##[2:5] array_write.valid;
    endproperty
    a_wr_go: assert property (p_wr_go) else $error("write not carried out");
    property p_wr_fields;
        array_write.valid |-> seen == $past(cw, 3) || seen == $past(cw, 4);
    endproperty
    a_wr_fields: assert property (p_wr_fields) else $error("write fields wrong");
    property p_sr_in;
        code == 4'h1 && !cke && $past(cke) && calm |-> ##[2:5] self_refresh;
    endproperty
    a_sr_in: assert property (p_sr_in) else $error("self refresh not entered");
    property p_dpd_in;
        code == 4'h6 && !cke && $past(cke) && calm |-> ##[2:5] deep_power_down;
    endproperty
    a_dpd_in: assert property (p_dpd_in) else $error("power-down not entered");
    property p_ref_len;
        $fell(refresh_busy) |-> busy_cnt_reg >= REFRESH_CYCLE_CYC - 1
            && busy_cnt_reg <= REFRESH_CYCLE_CYC + 1;
    endproperty
    a_ref_len: assert property (p_ref_len) else $error("refresh length wrong");
    property p_ref_row;
        $changed(refresh_row) |-> refresh_row == $past(refresh_row) + 14'h1;
    endproperty
    a_ref_row: assert property (p_ref_row) else $error("refresh row skipped");
    property p_quiet;
        cmd_pins.cs_n [*6] |-> !array_write.valid;
    endproperty
    a_quiet: assert property (p_quiet) else $error("write while deselected");
    property p_pre_all;
        code == 4'h2 && cmd_pins.addr[AP_BIT] && cke && $past(cke) && calm
            |-> ##[3:6] bank_state_out == 12'hdb6;
    endproperty
    a_pre_all: assert property (p_pre_all) else $error("not all banks closed");
endmodule
bind lbcs_bank_tracker lbcs_chk #(.NUM_BANKS(NUM_BANKS)) u_chk (.clock, .nrst, .cmd_pins,
    .cke, .write_data, .write_byte_mask, .array_write, .bank_state_out, .refresh_row,
    .refresh_busy, .self_refresh, .deep_power_down);

// ---- tb/lbcs_bank_command_state_tb_top.sv ----
// testbench: commands through the controller model, states and writes compared
`timescale 1ns/1ps
module lbcs_bank_command_state_tb_top;
    import lbcs_pkg::*;
    logic               clock = 1'b0;
    logic               nrst = 1'b0;
    lbcs_cmd_pins_t     cmd_pins;
    logic               cke;
    logic [BYTES*8-1:0] write_data;
    logic [BYTES-1:0]   write_byte_mask;
    lbcs_write_t        array_write;
    logic [3*BANKS-1:0] bank_state_out;
    logic [ROW_W-1:0]   refresh_row;
    logic               refresh_busy;
    logic               self_refresh;
    logic               deep_power_down;
    int                 failures = 0;
    int                 cmp_count = 0;
    int                 cyc = 0;
    int                 ref_m = 0;
    lbcs_write_t        exp_q[$];
    always #2.5 clock = ~clock;
    lbcs_ctrl_model u_ctrl (.clock, .cmd_pins, .cke, .write_data, .write_byte_mask);
    lbcs_bank_tracker uut (.clock, .nrst, .cmd_pins, .cke, .write_data, .write_byte_mask,
        .array_write, .bank_state_out, .refresh_row, .refresh_busy, .self_refresh,
        .deep_power_down);
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic run(input int n);
        repeat (n) @(negedge clock);
    endtask
    task automatic cmd(input logic [3:0] c, input logic [1:0] b, input logic [13:0] a,
                       input logic k);
        u_ctrl.put(c, b, a, k, 16'($urandom), 2'($urandom));
    endtask
    task automatic wait_st(input int b, input logic [2:0] st);
        for (int n = 0; n < 40 && bank_state_out[3*b +: 3] !== st; n++)
            @(negedge clock);
        chk(bank_state_out[3*b +: 3], st);
    endtask
    task automatic wr(input int b, input logic ap);
        logic [9:0]  col;
        logic [15:0] d;
        logic [1:0]  m;
        col = 10'($urandom);
        d = 16'($urandom);
        m = 2'($urandom);
        exp_q.push_back({1'b1, 2'(b), col, d, m});
        u_ctrl.put(4'h4, 2'(b), {3'h0, ap, col}, 1'b1, d, m);
    endtask
    task automatic do_ref(input logic row_chk);
        cmd(4'h1, 2'($urandom), 14'($urandom), 1'b1);
        for (int n = 0; n < 10 && refresh_busy !== 1'b1; n++)
            @(negedge clock);
        chk(refresh_busy, 1'b1);
        run(REFRESH_CYCLE_CYC + 4);
        chk(refresh_busy, 1'b0);
        ref_m++;
        if (row_chk)
            chk(refresh_row, 32'(ref_m));
    endtask
    // mode entry, an ignored write while in it, then exit on clock enable high
    task automatic mode(input logic [3:0] c);
        u_ctrl.idle_cke = 1'b0;
        cmd(c, 2'h0, 14'h0, 1'b0);
        run(6);
        chk({self_refresh, deep_power_down}, (c == 4'h1) ? 2'b10 : 2'b01);
        cmd(4'h4, 2'h1, 14'h0, 1'b0);
        run(6);
        u_ctrl.idle_cke = 1'b1;
        run(12);
        chk({self_refresh, deep_power_down}, 2'b00);
    endtask
    // looked at on the falling edge, where the registered outputs have settled
    always @(negedge clock) begin
        cyc++;
        if (cyc > 3000) begin
            failures++;
            report_and_stop();
        end else if (nrst && array_write.valid === 1'b1) begin
            if (exp_q.size() != 0)
                chk(array_write, exp_q.pop_front());
            else
                chk(array_write, 32'h0);
        end
    end
    initial begin
        int r;
        r = $urandom(21);
        run(2);
        chk(bank_state_out, 32'h0);
        chk(32'(array_write), 32'h0);
        chk(32'({refresh_row, refresh_busy, self_refresh, deep_power_down}), 32'h0);
        nrst = 1'b1;
        run(3);
        $display("test reset done");
        for (int b = 0; b < 4; b++) begin
            cmd(4'h3, 2'(b), 14'($urandom), 1'b1);
            wait_st(b, 3'd1);
            wait_st(b, 3'd2);
        end
        repeat (4) cmd(4'h7, 2'($urandom), 14'($urandom), 1'b1);
        run(10);
        chk(bank_state_out, 32'h492);
        $display("test activate done");
        for (int i = 0; i < 6; i++)
            wr(i / 2, 1'b0);
        run(16);
        chk(32'(exp_q.size()), 32'h0);
        chk(bank_state_out, 32'h492);
        wr(2, 1'b1);
        wait_st(2, 3'd5);
        wait_st(2, 3'd0);
        $display("test write done");
        cmd(4'h5, 2'h0, 14'h0, 1'b1);
        cmd(4'h6, 2'h0, 14'h0, 1'b1);
        // the read shows for a single cycle only when the terminate has taken
        wait_st(0, 3'd3);
        run(1);
        chk(bank_state_out[2:0], 3'd2);
        cmd(4'h2, 2'h1, 14'h3ff, 1'b1);
        wait_st(1, 3'd6);
        wait_st(1, 3'd0);
        chk(bank_state_out, 32'h402);
        for (int b = 1; b < 3; b++) begin
            cmd(4'h3, 2'(b), 14'h0, 1'b1);
            wait_st(b, 3'd2);
        end
        cmd(4'h2, 2'($urandom), 14'h400 | 14'($urandom), 1'b1);
        wait_st(0, 3'd6);
        run(10);
        chk(bank_state_out, 32'h0);
        // mode register load touches no bank state here
        cmd(4'h0, 2'($urandom), 14'($urandom), 1'b1);
        run(6);
        chk(bank_state_out, 32'h0);
        $display("test precharge done");
        repeat (3) do_ref(1'b1);
        mode(4'h1);
        do_ref(1'b0);
        mode(4'h6);
        $display("test refresh done");
        report_and_stop();
    end
endmodule

// ---- tb/lbcs_ctrl_model.sv ----
// far-side model: memory controller putting commands on the pins at the falling edge
`timescale 1ns/1ps
module lbcs_ctrl_model
    import lbcs_pkg::*;
(
    input  wire logic                clock,
    output lbcs_pkg::lbcs_cmd_pins_t cmd_pins,
    output logic                     cke,
    output logic [BYTES*8-1:0]       write_data,
    output logic [BYTES-1:0]         write_byte_mask
);
    logic [38:0] req_q[$];
    logic        idle_cke = 1'b1;
    // callers queue only commands legal for each bank state, apart from the write that mode sends to idle bank 1 in a low-power mode
    task automatic put(input logic [3:0] c, input logic [1:0] b, input logic [13:0] a,
                       input logic k, input logic [15:0] d, input logic [1:0] m);
        req_q.push_back({c, b, a, k, d, m});
    endtask
    initial begin
        cmd_pins = '1;
        cke = 1'b1;
        write_data = '0;
        write_byte_mask = '0;
    end
    // one request per edge; the clock is never stopped
    always @(negedge clock) begin
        logic [38:0] r;
        if (req_q.size() != 0)
            r = req_q.pop_front();
        else
            r = {1'b1, 19'($urandom), idle_cke, 18'($urandom)};
        cmd_pins = r[38:19];
        cke = r[18];
        write_data = r[17:2];
        write_byte_mask = r[1:0];
    end
endmodule
